// >>> pfs_pin_func_top.sv
`timescale 1ns/1ps
module pfs_pin_func_top
  import pfs_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [PFS_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [PFS_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [PFS_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [PFS_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [1:0]              pad_in,
  output logic [1:0]                   pad_out,
  output logic [1:0]                   pad_oe,
  input  wire logic [1:0]              general_io_out,
  input  wire logic [1:0]              general_io_oe,
  output logic [1:0]                   general_io_in,
  output logic                         shared_pin_irq_a,
  output logic                         shared_pin_irq_b,
  input  wire logic                    first_bus_slave_data_pull_low,
  output logic                         first_bus_slave_data_in,
  input  wire logic                    first_bus_slave_clock_pull_low,
  output logic                         first_bus_slave_clock_in,
  input  wire logic                    basic_serial_port_tx,
  output logic                         basic_serial_port_rx,
  input  wire logic                    fourth_serial_port_tx,
  output logic                         fourth_serial_port_rx,
  input  wire pfs_drive_t              capcomp_channel_two_drv,
  output logic                         capcomp_channel_two_in,
  input  wire pfs_drive_t              capcomp_channel_three_drv,
  output logic                         capcomp_channel_three_in,
  output logic [1:0]                   touch_key_enable,
  output logic [1:0]                   touch_key_level
);

  localparam int PIN12 = 0;
  localparam int PIN13 = 1;

  pfs_cfg_t                cfg_reg [PFS_PIN_COUNT];

  // Write channel state
  logic                    aw_hold_reg;
  logic [PFS_ADDR_W-1:0]   aw_addr_reg;
  logic                    w_hold_reg;
  logic [7:0]              w_byte_reg;
  logic                    w_lane0_reg;
  logic                    commit;
  logic                    wr_hit12;
  logic                    wr_hit13;
  logic                    rd_hit12;
  logic                    rd_hit13;

  // Pad synchroniser and observed levels
  logic [1:0]              pad_meta_reg;
  logic [1:0]              pad_sync_reg;
  logic [1:0]              irq_a_term;
  logic [1:0]              irq_b_term;
  pfs_drive_t              pad_drv      [PFS_PIN_COUNT];
  pfs_drive_t              capcomp_drv  [PFS_PIN_COUNT];
  logic [1:0]              slave_pull;

  assign capcomp_drv[PIN12] = capcomp_channel_two_drv;
  assign capcomp_drv[PIN13] = capcomp_channel_three_drv;
  assign slave_pull         = {first_bus_slave_clock_pull_low, first_bus_slave_data_pull_low};

  // Register decode: low two address bits ignored, word aligned
  assign wr_hit12 = aw_addr_reg[PFS_ADDR_W-1:2] == PFS_PIN12_ADDR[PFS_ADDR_W-1:2];
  assign wr_hit13 = aw_addr_reg[PFS_ADDR_W-1:2] == PFS_PIN13_ADDR[PFS_ADDR_W-1:2];
  assign rd_hit12 = s_axi_araddr[PFS_ADDR_W-1:2] == PFS_PIN12_ADDR[PFS_ADDR_W-1:2];
  assign rd_hit13 = s_axi_araddr[PFS_ADDR_W-1:2] == PFS_PIN13_ADDR[PFS_ADDR_W-1:2];

  // Write completes once both address and data are held and no response is pending
  assign commit = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  // Address and data are accepted independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_hold_reg   <= 1'b0;
      aw_addr_reg   <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_hold_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
    end
    else if (commit)
    begin
      aw_hold_reg   <= 1'b0;
    end
    else if (!aw_hold_reg && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_hold_reg   <= 1'b0;
      w_byte_reg   <= '0;
      w_lane0_reg  <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_hold_reg   <= 1'b1;
      w_byte_reg   <= s_axi_wdata[7:0];
      w_lane0_reg  <= s_axi_wstrb[0];
    end
    else if (commit)
    begin
      w_hold_reg   <= 1'b0;
    end
    else if (!w_hold_reg && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // Unmapped writes are dropped and answered with a decode error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PFS_RESP_OKAY;
    end
    else if (commit)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit12 || wr_hit13) ? PFS_RESP_OKAY : PFS_RESP_DECERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_reg[PIN12] <= pfs_cfg_t'(PFS_CFG_RESET);
    else if (commit && wr_hit12 && w_lane0_reg)
      cfg_reg[PIN12] <= pfs_cfg_t'(w_byte_reg);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_reg[PIN13] <= pfs_cfg_t'(PFS_CFG_RESET);
    else if (commit && wr_hit13 && w_lane0_reg)
      cfg_reg[PIN13] <= pfs_cfg_t'(w_byte_reg);
  end

  // One read at a time; data leave a register one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= PFS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (rd_hit12 || rd_hit13) ? PFS_RESP_OKAY : PFS_RESP_DECERR;
      if (rd_hit12)
        s_axi_rdata <= {24'h00_0000, cfg_reg[PIN12]};
      else if (rd_hit13)
        s_axi_rdata <= {24'h00_0000, cfg_reg[PIN13]};
      else
        s_axi_rdata <= '0;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // Pads are asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
    end
    else
    begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  genvar p;
  generate
    for (p = 0; p < PFS_PIN_COUNT; p++)
    begin : g_pin
      pfs_pin_mux #(
        .SERIAL_DRIVES_PIN (p == PIN12)
      ) u_mux (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .cfg              (cfg_reg[p]),
        .slave_pull_low   (slave_pull[p]),
        .basic_serial_tx  (basic_serial_port_tx),
        .fourth_serial_tx (fourth_serial_port_tx),
        .capcomp_drv      (capcomp_drv[p]),
        .general_drv      ('{out: general_io_out[p], oe: general_io_oe[p]}),
        .pad_drv          (pad_drv[p]),
        .pad_src          ()
      );

      assign pad_out[p] = pad_drv[p].out;
      assign pad_oe[p]  = pad_drv[p].oe;

      assign irq_a_term[p] = cfg_reg[p].shared_irq_a_select && pad_sync_reg[p];
      assign irq_b_term[p] = cfg_reg[p].shared_irq_b_select && pad_sync_reg[p];

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          general_io_in[p] <= 1'b0;
        else
          general_io_in[p] <= cfg_reg[p].general_io_select && pad_sync_reg[p];
      end

      // Touch sensing is analog; only the enable and the observed level are passed on
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          touch_key_enable[p] <= 1'b0;
          touch_key_level[p]  <= 1'b0;
        end
        else
        begin
          touch_key_enable[p] <= cfg_reg[p].touch_key_select;
          touch_key_level[p]  <= cfg_reg[p].touch_key_select && pad_sync_reg[p];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shared_pin_irq_a <= 1'b0;
      shared_pin_irq_b <= 1'b0;
    end
    else
    begin
      shared_pin_irq_a <= |irq_a_term;
      shared_pin_irq_b <= |irq_b_term;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_bus_slave_data_in  <= PFS_IDLE_LINE_HIGH;
      first_bus_slave_clock_in <= PFS_IDLE_LINE_HIGH;
      basic_serial_port_rx     <= PFS_IDLE_LINE_HIGH;
      fourth_serial_port_rx    <= PFS_IDLE_LINE_HIGH;
    end
    else
    begin
      first_bus_slave_data_in  <= cfg_reg[PIN12].bus_slave_line_select ?
                                  pad_sync_reg[PIN12] : PFS_IDLE_LINE_HIGH;
      first_bus_slave_clock_in <= cfg_reg[PIN13].bus_slave_line_select ?
                                  pad_sync_reg[PIN13] : PFS_IDLE_LINE_HIGH;
      basic_serial_port_rx     <= cfg_reg[PIN13].basic_serial_select ?
                                  pad_sync_reg[PIN13] : PFS_IDLE_LINE_HIGH;
      fourth_serial_port_rx    <= cfg_reg[PIN13].fourth_serial_select ?
                                  pad_sync_reg[PIN13] : PFS_IDLE_LINE_HIGH;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capcomp_channel_two_in   <= PFS_IDLE_LINE_LOW;
      capcomp_channel_three_in <= PFS_IDLE_LINE_LOW;
    end
    else
    begin
      capcomp_channel_two_in   <= cfg_reg[PIN12].capcomp_io_select ?
                                  pad_sync_reg[PIN12] : PFS_IDLE_LINE_LOW;
      capcomp_channel_three_in <= cfg_reg[PIN13].capcomp_io_select ?
                                  pad_sync_reg[PIN13] : PFS_IDLE_LINE_LOW;
    end
  end

endmodule

// >>> pfs_pkg.sv
package pfs_pkg;

  // Bus geometry
  localparam int              PFS_ADDR_W     = 20;
  localparam int              PFS_DATA_W     = 32;
  localparam int              PFS_PIN_COUNT  = 2;

  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [15:0]     PFS_PIN12_IDX  = 16'ha05a;
  localparam logic [15:0]     PFS_PIN13_IDX  = 16'ha05b;
  localparam logic [PFS_ADDR_W-1:0] PFS_PIN12_ADDR = {2'b00, PFS_PIN12_IDX, 2'b00};
  localparam logic [PFS_ADDR_W-1:0] PFS_PIN13_ADDR = {2'b00, PFS_PIN13_IDX, 2'b00};

  // Field positions inside each configuration register
  localparam int              PFS_BIT_GENERAL_IO   = 0;
  localparam int              PFS_BIT_SHARED_IRQ_A = 1;
  localparam int              PFS_BIT_SHARED_IRQ_B = 2;
  localparam int              PFS_BIT_FOURTH_SER   = 3;
  localparam int              PFS_BIT_CAPCOMP      = 4;
  localparam int              PFS_BIT_BASIC_SER    = 5;
  localparam int              PFS_BIT_BUS_SLAVE    = 6;
  localparam int              PFS_BIT_TOUCH_KEY    = 7;

  // Reset value of both configuration registers
  localparam logic [7:0]      PFS_CFG_RESET  = 8'h00;

  // Bus response codes
  localparam logic [1:0]      PFS_RESP_OKAY   = 2'b00;
  localparam logic [1:0]      PFS_RESP_DECERR = 2'b11;

  // Idle levels presented to peripherals whose pin is not routed
  localparam logic            PFS_IDLE_LINE_HIGH = 1'b1;
  localparam logic            PFS_IDLE_LINE_LOW  = 1'b0;

  // Configuration register layout, bit 7 first
  typedef struct packed {
    logic touch_key_select;
    logic bus_slave_line_select;
    logic basic_serial_select;
    logic capcomp_io_select;
    logic fourth_serial_select;
    logic shared_irq_b_select;
    logic shared_irq_a_select;
    logic general_io_select;
  } pfs_cfg_t;

  // Output value and enable of one pad or one peripheral
  typedef struct packed {
    logic out;
    logic oe;
  } pfs_drive_t;

  // Function that currently owns the pad driver
  typedef enum logic [2:0] {
    PFS_SRC_NONE      = 3'b000,
    PFS_SRC_GENERAL   = 3'b001,
    PFS_SRC_FOURTH    = 3'b010,
    PFS_SRC_CAPCOMP   = 3'b011,
    PFS_SRC_BASIC     = 3'b100,
    PFS_SRC_BUS_SLAVE = 3'b101
  } pfs_src_t;

endpackage

// >>> pfs_pin_mux.sv
`timescale 1ns/1ps
module pfs_pin_mux
  import pfs_pkg::*;
#(
  parameter logic SERIAL_DRIVES_PIN = 1'b1
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire pfs_cfg_t   cfg,
  input  wire logic       slave_pull_low,
  input  wire logic       basic_serial_tx,
  input  wire logic       fourth_serial_tx,
  input  wire pfs_drive_t capcomp_drv,
  input  wire pfs_drive_t general_drv,
  output pfs_drive_t      pad_drv,
  output pfs_src_t        pad_src
);

  pfs_src_t   src_next;
  pfs_drive_t drv_next;

  always_comb
  begin
    src_next = PFS_SRC_NONE;
    if (cfg.bus_slave_line_select)
      src_next = PFS_SRC_BUS_SLAVE;
    else if (cfg.basic_serial_select && SERIAL_DRIVES_PIN)
      src_next = PFS_SRC_BASIC;
    else if (cfg.capcomp_io_select)
      src_next = PFS_SRC_CAPCOMP;
    else if (cfg.fourth_serial_select && SERIAL_DRIVES_PIN)
      src_next = PFS_SRC_FOURTH;
    else if (cfg.general_io_select)
      src_next = PFS_SRC_GENERAL;
  end

  always_comb
  begin
    drv_next = '0;
    case (src_next)
      PFS_SRC_BUS_SLAVE: drv_next = '{out: 1'b0, oe: slave_pull_low};
      PFS_SRC_BASIC:     drv_next = '{out: basic_serial_tx, oe: 1'b1};
      PFS_SRC_CAPCOMP:   drv_next = capcomp_drv;
      PFS_SRC_FOURTH:    drv_next = '{out: fourth_serial_tx, oe: 1'b1};
      PFS_SRC_GENERAL:   drv_next = general_drv;
      default:           drv_next = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_drv <= '0;
      pad_src <= PFS_SRC_NONE;
    end
    else
    begin
      pad_drv <= drv_next;
      pad_src <= src_next;
    end
  end

endmodule

// >>> pfs_pin_func_asserts.sv
`timescale 1ns/1ps
module pfs_pin_func_asserts
  import pfs_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [1:0]            pad_in,
  input wire logic [1:0]            general_io_in,
  input wire logic                  shared_pin_irq_a,
  input wire logic                  shared_pin_irq_b,
  input wire logic                  first_bus_slave_data_in,
  input wire logic                  basic_serial_port_rx,
  input wire logic                  capcomp_channel_two_in,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [PFS_DATA_W-1:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Observers lag the pad by two sync flops and one output flop
  property p_gpio_in; general_io_in[0] |-> $past(pad_in[0], 3); endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("gpio input high with pad low");
  property p_irq_a; shared_pin_irq_a |-> $past(pad_in, 3) != 2'h0; endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a without pad high");
  property p_irq_b; shared_pin_irq_b |-> $past(pad_in, 3) != 2'h0; endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b without pad high");
  property p_sda; !first_bus_slave_data_in |-> !$past(pad_in[0], 3); endproperty
  a_sda: assert property (p_sda) else $error("slave data low with pad high");
  property p_rx; !basic_serial_port_rx |-> !$past(pad_in[1], 3); endproperty
  a_rx: assert property (p_rx) else $error("serial rx low with pad high");
  property p_cap2; capcomp_channel_two_in |-> $past(pad_in[0], 3); endproperty
  a_cap2: assert property (p_cap2) else $error("capcomp input high with pad low");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_r_upper: assert property (p_r_upper) else $error("read data above byte");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_both_irq: cover property (shared_pin_irq_a && shared_pin_irq_b);
  c_sda_low: cover property (!first_bus_slave_data_in);
endmodule
bind pfs_pin_func_top pfs_pin_func_asserts u_chk (.aclk, .aresetn, .pad_in, .general_io_in, .shared_pin_irq_a,
  .shared_pin_irq_b, .first_bus_slave_data_in, .basic_serial_port_rx, .capcomp_channel_two_in, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// >>> pfs_pad_model.sv
`timescale 1ns/1ps
module pfs_pad_model
(
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe,
  input  wire logic [1:0] ext_val,
  input  wire logic [1:0] ext_oe,
  output logic [1:0]      pad_in
);
  // pull-up on pads
  // Released pads float high, which open-drain bus lines rely on
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_oe[i])
        pad_in[i] = ext_val[i];
      else
        pad_in[i] = 1'b1;
    end
  end
endmodule

// >>> port1_pin2_3_function_select_tb.sv
`timescale 1ns/1ps
module port1_pin2_3_function_select_tb;
  import pfs_pkg::*;
  localparam logic [19:0] BAD = 20'h0_0100;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, shared_pin_irq_a, shared_pin_irq_b;
  logic first_bus_slave_data_pull_low, first_bus_slave_data_in, first_bus_slave_clock_pull_low;
  logic first_bus_slave_clock_in, basic_serial_port_tx, basic_serial_port_rx, fourth_serial_port_tx;
  logic fourth_serial_port_rx, capcomp_channel_two_in, capcomp_channel_three_in;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pad_in, pad_out, pad_oe, general_io_out, general_io_oe;
  logic [1:0]  general_io_in, touch_key_enable, touch_key_level, ext_val, ext_oe, r;
  pfs_drive_t  capcomp_channel_two_drv, capcomp_channel_three_drv;
  int          fails = 0, n_compared = 0, cyc = 0;

  pfs_pin_func_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out,
    .pad_oe, .general_io_out, .general_io_oe, .general_io_in, .shared_pin_irq_a, .shared_pin_irq_b,
    .first_bus_slave_data_pull_low, .first_bus_slave_data_in, .first_bus_slave_clock_pull_low,
    .first_bus_slave_clock_in, .basic_serial_port_tx, .basic_serial_port_rx, .fourth_serial_port_tx,
    .fourth_serial_port_rx, .capcomp_channel_two_drv, .capcomp_channel_two_in, .capcomp_channel_three_drv,
    .capcomp_channel_three_in, .touch_key_enable, .touch_key_level);
  pfs_pad_model pads (.pad_out, .pad_oe, .ext_val, .ext_oe, .pad_in);

  always #12.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Handshakes are judged at the rising edge; ready is raised late on purpose so the hold checks see a stall
  task automatic wr(input logic [19:0] a, input logic [7:0] v, input logic [3:0] s, output logic [1:0] resp);
    logic done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
      else if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end
  endtask

  task automatic rc(input logic [19:0] a, input logic [31:0] e, input logic [1:0] er);
    logic       done;
    logic [1:0] rr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    done = 1'b0;
    rr = 2'h0;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
      else if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
    end
    chk(d, e, "read data");
    chk({30'h0, rr}, {30'h0, er}, "read resp");
  endtask

  // One edge of pad mux, then three edges to the observers
  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_reset();
    chk(pad_oe, 2'h0, "pad driven after reset");
    chk(general_io_in, 2'h0, "gpio input after reset");
    rc(PFS_PIN12_ADDR, 32'h0000_0000, PFS_RESP_OKAY);
    rc(PFS_PIN13_ADDR, 32'h0000_0000, PFS_RESP_OKAY);
    rc(BAD, 32'h0000_0000, PFS_RESP_DECERR);
  endtask

  task automatic t_regs();
    wr(PFS_PIN12_ADDR, 8'ha5, 4'h1, r);
    chk(r, PFS_RESP_OKAY, "write resp");
    wr(PFS_PIN13_ADDR, 8'h5a, 4'h1, r);
    wr(PFS_PIN13_ADDR, 8'hff, 4'h0, r);
    wr(BAD, 8'h11, 4'h1, r);
    chk(r, PFS_RESP_DECERR, "unmapped write");
    rc(PFS_PIN12_ADDR, 32'h0000_00a5, PFS_RESP_OKAY);
    rc(PFS_PIN13_ADDR, 32'h0000_005a, PFS_RESP_OKAY);
  endtask

  task automatic t_gpio();
    @(posedge aclk);
    general_io_out <= 2'h1;
    general_io_oe <= 2'h1;
    wr(PFS_PIN12_ADDR, 8'h01, 4'h1, r);
    wr(PFS_PIN13_ADDR, 8'h01, 4'h1, r);
    ext_oe <= 2'h2;
    settle();
    chk({pad_out[0], pad_oe[0]}, 2'h3, "gpio drive");
    chk(general_io_in, 2'h1, "gpio input");
    @(posedge aclk);
    ext_val <= 2'h2;
    settle();
    chk(general_io_in, 2'h3, "gpio input high");
  endtask

  task automatic t_irq();
    wr(PFS_PIN12_ADDR, 8'h86, 4'h1, r);
    wr(PFS_PIN13_ADDR, 8'h02, 4'h1, r);
    ext_oe <= 2'h3;
    ext_val <= 2'h1;
    settle();
    chk({shared_pin_irq_a, shared_pin_irq_b}, 2'h3, "one pin both irqs");
    chk({touch_key_enable, touch_key_level}, 4'h5, "touch key");
    @(posedge aclk);
    ext_val <= 2'h2;
    settle();
    chk({shared_pin_irq_a, shared_pin_irq_b}, 2'h2, "second pin to irq a");
    @(posedge aclk);
    ext_val <= 2'h0;
    settle();
    chk(shared_pin_irq_a, 1'b0, "irq a idle");
  endtask

  task automatic t_prio();
    logic [7:0] cfg [5] = '{8'h78, 8'h38, 8'h18, 8'h08, 8'h01};
    logic [1:0] exp [5] = '{2'h1, 2'h3, 2'h1, 2'h1, 2'h1};
    @(posedge aclk);
    first_bus_slave_data_pull_low <= 1'b1;
    capcomp_channel_two_drv <= pfs_drive_t'(2'h1);
    general_io_out <= 2'h0;
    ext_oe <= 2'h0;
    for (int i = 0; i < 5; i++)
    begin
      wr(PFS_PIN12_ADDR, cfg[i], 4'h1, r);
      settle();
      chk({pad_out[0], pad_oe[0]}, exp[i], "drive priority");
      if (i == 0)
        chk(first_bus_slave_data_in, 1'b0, "slave data in");
    end
    wr(PFS_PIN12_ADDR, 8'h10, 4'h1, r);
    capcomp_channel_two_drv <= pfs_drive_t'(2'h3);
    settle();
    chk({pad_out[0], capcomp_channel_two_in}, 2'h3, "capcomp io");
  endtask

  // Pin 1.3 serial bits only observe, so the gpio drive must win over them
  task automatic t_pin13();
    logic [7:0] cfg [3] = '{8'h61, 8'h09, 8'h10};
    logic [5:0] exp [3] = '{6'h12, 6'h1c, 6'h3f};
    @(posedge aclk);
    first_bus_slave_clock_pull_low <= 1'b1;
    capcomp_channel_three_drv <= pfs_drive_t'(2'h3);
    general_io_oe <= 2'h2;
    for (int i = 0; i < 3; i++)
    begin
      wr(PFS_PIN13_ADDR, cfg[i], 4'h1, r);
      settle();
      chk({pad_out[1], pad_oe[1], first_bus_slave_clock_in, basic_serial_port_rx, fourth_serial_port_rx,
           capcomp_channel_three_in}, exp[i], "pin 1.3 map");
    end
  endtask

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 20'h0_0000;
    s_axi_araddr = 20'h0_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    general_io_out = 2'h3;
    general_io_oe = 2'h3;
    ext_val = 2'h0;
    ext_oe = 2'h0;
    first_bus_slave_data_pull_low = 1'b0;
    first_bus_slave_clock_pull_low = 1'b0;
    basic_serial_port_tx = 1'b1;
    fourth_serial_port_tx = 1'b0;
    capcomp_channel_two_drv = pfs_drive_t'(2'h0);
    capcomp_channel_three_drv = pfs_drive_t'(2'h0);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset();
    t_regs();
    t_gpio();
    t_irq();
    t_prio();
    t_pin13();
    finish_test();
  end
endmodule
